// *** shared/dsd_pkg.sv ***
// package for the dp slave device-specific diagnostic builder
// assumes a single 50 MHz clock domain and an apb register port
package dsd_pkg;
  // register byte addresses
  localparam logic [7:0] DSD_OFS_STATUS = 8'h00;
  localparam logic [7:0] DSD_OFS_PAYLOAD_LO = 8'h04;
  localparam logic [7:0] DSD_OFS_PAYLOAD_HI = 8'h08;
  localparam logic [7:0] DSD_OFS_ERROR = 8'h0c;
  localparam logic [7:0] DSD_OFS_CTRL = 8'h10;
  localparam logic [7:0] DSD_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] DSD_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] DSD_OFS_DIAG_LO = 8'h1c;
  localparam logic [7:0] DSD_OFS_DIAG_MID = 8'h20;
  localparam logic [7:0] DSD_OFS_DIAG_HI = 8'h24;
  // status byte fields
  localparam int DSD_ST_VALID_BIT = 0;
  localparam int DSD_ST_DELETE_BIT = 1;
  localparam logic [7:0] DSD_ST_BOTH = 8'h03;
  // header byte 6
  localparam logic [5:0] DSD_HDR_LEN = 6'h0a;
  localparam logic [1:0] DSD_HDR_CODE = 2'h0;
  // message codes in byte 7
  localparam logic [7:0] DSD_MSG_NONE = 8'h00;
  localparam logic [7:0] DSD_MSG_PRM_LEN = 8'h12;
  localparam logic [7:0] DSD_MSG_CFG_LEN = 8'h13;
  localparam logic [7:0] DSD_MSG_CFG_ENTRY = 8'h14;
  localparam logic [7:0] DSD_MSG_BUF_CALC = 8'h15;
  localparam logic [7:0] DSD_MSG_CFG_MISSING = 8'h16;
  localparam logic [7:0] DSD_MSG_PRM_CFG = 8'h17;
  localparam logic [7:0] DSD_MSG_USER_VALID = 8'h40;
  // error flag positions (one per error code, 12h..17h)
  localparam int DSD_NUM_ERR = 6;
  // irq status bits
  localparam int DSD_IRQ_SENT = 0;
  localparam int DSD_IRQ_ERR = 1;
  localparam int DSD_IRQ_DEL = 2;
  // reset values
  localparam logic [7:0] DSD_RST_STATUS = 8'h00;
  localparam logic [39:0] DSD_RST_PAYLOAD = 40'h0;
  localparam logic [2:0] DSD_RST_MASK = 3'h0;

  // device-specific diagnostic bytes 6..15
  typedef struct packed {
    logic [7:0] header;
    logic [7:0] message;
    logic [23:0] reserved;
    logic [39:0] user;
  } dsd_diag_t;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dsd_apb_req_t;
endpackage : dsd_pkg

// *** hw/dsd_msg_sel.sv ***
// message code selection for diagnostic byte 7
// assumes error flags are sticky levels from the main block
`timescale 1ns/1ns
module dsd_msg_sel
  import dsd_pkg::*;
(
  // inputs
  input wire logic [DSD_NUM_ERR-1:0] err_flags,
  input wire logic user_valid,
  // output
  output logic [7:0] msg_code
);
  // errors outrank user data; lowest code first
  always_comb
  begin
    msg_code = DSD_MSG_NONE;
    if (user_valid)
      msg_code = DSD_MSG_USER_VALID;
    if (err_flags[5])
      msg_code = DSD_MSG_PRM_CFG;
    if (err_flags[4])
      msg_code = DSD_MSG_CFG_MISSING;
    if (err_flags[3])
      msg_code = DSD_MSG_BUF_CALC;
    if (err_flags[2])
      msg_code = DSD_MSG_CFG_ENTRY;
    if (err_flags[1])
      msg_code = DSD_MSG_CFG_LEN;
    if (err_flags[0])
      msg_code = DSD_MSG_PRM_LEN;
  end
endmodule : dsd_msg_sel

// *** hw/dsd_diag_builder.sv ***
// builds diagnostic bytes 6..15 for a dp slave; apb register port
// assumes the protocol side gives one-cycle request and error pulses
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module dsd_diag_builder
  import dsd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol side
  input wire logic diag_req,
  input wire logic [DSD_NUM_ERR-1:0] err_event,
  output logic diag_send,
  output dsd_diag_t diag_data,
  output logic fieldbus_en,
  output logic fieldbus_led,
  // interrupt
  output logic irq
);
  dsd_apb_req_t req;
  logic wr_en;
  logic rd_en;
  logic [7:0] status_q;
  logic [7:0] status_prev_q;
  logic [39:0] payload_q;
  logic [DSD_NUM_ERR-1:0] err_q;
  logic user_valid_q;
  logic fb_en_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  logic start_pulse;
  logic delete_pulse;
  logic err_any;
  logic send_d;
  logic send_q;
  logic [7:0] msg_code;
  dsd_diag_t diag_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic stat_rd;
  logic both_set;
  logic user_valid_d;
  logic [DSD_NUM_ERR-1:0] err_next;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = req.psel && req.penable && req.pwrite;
  assign rd_en = req.psel && req.penable && !req.pwrite;

  // unmapped offsets answer with an error
  always_comb
  begin
    unique case (req.paddr)
      DSD_OFS_STATUS, DSD_OFS_PAYLOAD_LO, DSD_OFS_PAYLOAD_HI, DSD_OFS_ERROR,
      DSD_OFS_CTRL, DSD_OFS_IRQ_STAT, DSD_OFS_IRQ_MASK, DSD_OFS_DIAG_LO,
      DSD_OFS_DIAG_MID, DSD_OFS_DIAG_HI:
        pslverr = 1'b0;
      default:
        pslverr = req.psel && req.penable;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      status_q <= DSD_RST_STATUS;
    else if (wr_en && req.paddr == DSD_OFS_STATUS && pstrb[0])
      status_q <= req.pwdata[7:0];
  end

  // payload bytes 1..5, byte lanes honoured
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      payload_q <= DSD_RST_PAYLOAD;
    else if (wr_en)
    begin
      // block byte 1 sits in the top byte so it leaves first, as byte 11
      if (req.paddr == DSD_OFS_PAYLOAD_LO)
      begin
        for (int i = 0; i < 4; i++)
          if (pstrb[i])
            payload_q[32-8*i +: 8] <= req.pwdata[8*i +: 8];
      end
      else if (req.paddr == DSD_OFS_PAYLOAD_HI && pstrb[0])
        payload_q[7:0] <= req.pwdata[7:0];
    end
  end

  // previous status for edge detection
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      status_prev_q <= DSD_RST_STATUS;
    else
      status_prev_q <= status_q;
  end

  // only bits 0 and 1 are looked at
  assign both_set = (status_q[1:0] == DSD_ST_BOTH[1:0]);
  // rising valid bit starts a diagnostic
  assign start_pulse = !both_set && status_q[DSD_ST_VALID_BIT]
    && !status_prev_q[DSD_ST_VALID_BIT];
  assign delete_pulse = !both_set && status_q[DSD_ST_DELETE_BIT]
    && !status_prev_q[DSD_ST_DELETE_BIT];

  // valid indication follows bit 0 start
  always_comb
  begin
    user_valid_d = user_valid_q;
    if (start_pulse)
      user_valid_d = 1'b1;
    else if (delete_pulse)
      user_valid_d = 1'b0;
    else if (!status_q[DSD_ST_VALID_BIT])
      user_valid_d = 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      user_valid_q <= 1'b0;
    else
      user_valid_q <= user_valid_d;
  end

  // sticky error flags; a new event wins over a software clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      err_q <= '0;
    else if (wr_en && req.paddr == DSD_OFS_ERROR && pstrb[0])
      err_q <= (err_q & ~req.pwdata[DSD_NUM_ERR-1:0]) | err_event;
    else
      err_q <= err_q | err_event;
  end

  // fieldbus section stays off until software enables it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      fb_en_q <= 1'b0;
    else if (wr_en && req.paddr == DSD_OFS_CTRL && pstrb[0])
      fb_en_q <= req.pwdata[0];
  end

  // the frame sent with an event must already carry that event's code
  assign err_next = err_q | err_event;

  dsd_msg_sel u_msg_sel (
    .err_flags(err_next),
    .user_valid(user_valid_d),
    .msg_code(msg_code)
  );

  assign err_any = |err_event;
  // send on request, error or user start
  assign send_d = fb_en_q && (diag_req || err_any || start_pulse);

  // response image is registered as the send pulse fires
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      send_q <= 1'b0;
      diag_q <= '0;
    end
    else
    begin
      send_q <= send_d;
      // image only moves on a send, so readback shows the last frame
      if (send_d)
      begin
        diag_q.header[5:0] <= DSD_HDR_LEN;
        diag_q.header[7:6] <= DSD_HDR_CODE;
        diag_q.message <= msg_code;
        diag_q.reserved <= '0;
        diag_q.user <= payload_q;
      end
    end
  end

  assign diag_send = send_q;
  assign diag_data = diag_q;
  assign fieldbus_en = fb_en_q;
  // led follows the section enable; off while deactivated
  assign fieldbus_led = fb_en_q;

  // interrupt sources
  assign irq_set[DSD_IRQ_SENT] = send_q;
  assign irq_set[DSD_IRQ_ERR] = err_any;
  assign irq_set[DSD_IRQ_DEL] = delete_pulse;
  assign stat_rd = rd_en && req.paddr == DSD_OFS_IRQ_STAT;

  // read clears, but a same-cycle event survives
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat_q <= '0;
    else if (stat_rd)
      irq_stat_q <= irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_mask_q <= DSD_RST_MASK;
    else if (wr_en && req.paddr == DSD_OFS_IRQ_MASK && pstrb[0])
      irq_mask_q <= req.pwdata[2:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read mux
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (req.paddr)
      DSD_OFS_STATUS:
        rdata_d = {24'h0, status_q};
      DSD_OFS_PAYLOAD_LO:
        rdata_d = {payload_q[15:8], payload_q[23:16], payload_q[31:24], payload_q[39:32]};
      DSD_OFS_PAYLOAD_HI:
        rdata_d = {24'h0, payload_q[7:0]};
      DSD_OFS_ERROR:
        rdata_d = {26'h0, err_q};
      DSD_OFS_CTRL:
        rdata_d = {30'h0, user_valid_q, fb_en_q};
      // a bit set in the setup cycle would otherwise be cleared unseen
      DSD_OFS_IRQ_STAT:
        rdata_d = {29'h0, irq_stat_q | irq_set};
      DSD_OFS_IRQ_MASK:
        rdata_d = {29'h0, irq_mask_q};
      // frame bytes in ascending lanes: 6-9, 10-13, 14-15
      DSD_OFS_DIAG_LO:
        rdata_d = {diag_q.reserved[15:8], diag_q.reserved[23:16], diag_q.message,
          diag_q.header};
      DSD_OFS_DIAG_MID:
        rdata_d = {diag_q.user[23:16], diag_q.user[31:24], diag_q.user[39:32],
          diag_q.reserved[7:0]};
      DSD_OFS_DIAG_HI:
        rdata_d = {16'h0, diag_q.user[7:0], diag_q.user[15:8]};
      default:
        rdata_d = 32'h0;
    endcase
  end

  // read data held in a flop, loaded in the setup cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0;
    else if (req.psel && !req.penable)
      rdata_q <= rdata_d;
  end

  assign prdata = rdata_q;
endmodule : dsd_diag_builder

// *** tb/dsd_diag_builder_properties.sv ***
// port checker for the diagnostic builder
// assumes one mclk domain, sys_rst async high
`timescale 1ns/1ns
module dsd_diag_builder_properties
  import dsd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // protocol side
  input wire logic diag_req,
  input wire logic [DSD_NUM_ERR-1:0] err_event,
  input wire logic diag_send,
  input wire dsd_diag_t diag_data,
  input wire logic fieldbus_en,
  input wire logic fieldbus_led
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_hdr; diag_send |-> diag_data.header == 8'h0a; endproperty
  a_hdr: assert property (p_hdr) else $error("bad header");
  property p_req; diag_req && fieldbus_en |=> diag_send; endproperty
  a_req: assert property (p_req) else $error("poll not answered");
  property p_err; err_event[0] && fieldbus_en |=> diag_send && diag_data.message == 8'h12; endproperty
  a_err: assert property (p_err) else $error("error code wrong");
  property p_msg; diag_send |-> diag_data.message inside {8'h00, [8'h12:8'h17], 8'h40}; endproperty
  a_msg: assert property (p_msg) else $error("unknown code");
  property p_led; fieldbus_led == fieldbus_en; endproperty
  a_led: assert property (p_led) else $error("led differs");
  property p_off; !fieldbus_en [*3] |-> !diag_send; endproperty
  a_off: assert property (p_off) else $error("send while off");
  property p_on; $rose(fieldbus_en) |-> $past(psel && penable && pwrite && paddr == 8'h10); endproperty
  a_on: assert property (p_on) else $error("enable without write");
  property p_bad; psel && penable && paddr > 8'h24 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped accepted");
endmodule : dsd_diag_builder_properties

bind dsd_diag_builder dsd_diag_builder_properties i_dsd_diag_builder_properties (.mclk,
  .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .diag_req, .err_event,
  .diag_send, .diag_data, .fieldbus_en, .fieldbus_led);

// *** tb/dsd_master_model.sv ***
// dp master model: polls, counts frames and keeps the last one
// assumes diag_send is a one-cycle pulse
`timescale 1ns/1ns
module dsd_master_model
  import dsd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // slave side
  input wire logic poll,
  output logic diag_req,
  input wire logic diag_send,
  input wire dsd_diag_t diag_data,
  // capture
  output dsd_diag_t last_diag,
  output logic [7:0] n_rx
);
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      diag_req <= 1'b0;
    else
      diag_req <= poll && !diag_req;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      n_rx <= 8'h00;
    else if (diag_send)
      n_rx <= n_rx + 8'h01;
  always_ff @(posedge mclk)
    if (diag_send)
      last_diag <= diag_data;
endmodule : dsd_master_model

// *** tb/tb_top.sv ***
// bench: apb master, error pulses, master model
// assumes zero-wait apb slave, one clock
`timescale 1ns/1ns
module tb_top
  import dsd_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, poll = 1'b0, e;
  logic [7:0] paddr = 8'h00, n_rx;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, diag_req, diag_send, fieldbus_en, fieldbus_led, irq;
  logic [DSD_NUM_ERR-1:0] err_event = '0;
  dsd_diag_t diag_data, last_diag;
  logic [15:0] lfsr = 16'h86f8;
  logic [39:0] user = 40'h0;
  logic [7:0] st [3] = '{8'h01, 8'h03, 8'hfd};
  int n_mismatch = 0, check_count = 0;
  always #10 mclk = ~mclk;
  dsd_diag_builder i_dsd_diag_builder (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .diag_req, .err_event, .diag_send,
    .diag_data, .fieldbus_en, .fieldbus_led, .irq);
  dsd_master_model i_dsd_master_model (.mclk, .sys_rst, .poll, .diag_req, .diag_send,
    .diag_data, .last_diag, .n_rx);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: reg %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_diag(input dsd_diag_t got, input dsd_diag_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: frame %h exp %h", $time, got, exp);
    end
  endtask : cmp_diag
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // waits for a frame; want 0 means none may come
  task automatic frames(input logic [7:0] msg, input logic [7:0] want);
    logic [7:0] n0;
    n0 = n_rx;
    repeat (8)
      if (n_rx == n0)
        @(posedge mclk);
    cmp_reg({24'h0, 8'(n_rx - n0)}, {24'h0, want});
    if (want != 8'h00)
      cmp_diag(last_diag, {8'h0a, msg, 24'h0, user});
  endtask : frames
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, DSD_OFS_CTRL, 0);
    cmp_reg({r[29:0], fieldbus_led, fieldbus_en}, 0);
    apb(0, 8'h28, 32'hffffffff);
    cmp_reg({r[30:0], e}, 1);
    apb(1, DSD_OFS_CTRL, 1);
    apb(1, DSD_OFS_IRQ_MASK, 2);
    $display("test reset done");
    foreach (st[i])
    begin
      repeat (3)
      begin
        lfsr = lfsr_next(lfsr);
        user = {user[23:0], lfsr};
      end
      apb(1, DSD_OFS_PAYLOAD_LO, {user[15:8], user[23:16], user[31:24], user[39:32]});
      apb(1, DSD_OFS_PAYLOAD_HI, {24'h0, user[7:0]});
      apb(1, DSD_OFS_STATUS, 0);
      apb(1, DSD_OFS_STATUS, {24'h0, st[i]});
      frames(DSD_MSG_USER_VALID, {7'h0, st[i] != DSD_ST_BOTH});
    end
    apb(1, DSD_OFS_STATUS, 2);
    apb(0, DSD_OFS_CTRL, 0);
    cmp_reg(r, 1);
    poll <= 1'b1;
    @(posedge mclk);
    poll <= 1'b0;
    frames(DSD_MSG_NONE, 1);
    apb(0, DSD_OFS_DIAG_MID, 0);
    cmp_reg(r, {user[23:16], user[31:24], user[39:32], 8'h00});
    apb(0, DSD_OFS_DIAG_HI, 0);
    cmp_reg(r, {16'h0, user[7:0], user[15:8]});
    cmp_reg({31'h0, irq}, 0);
    apb(0, DSD_OFS_IRQ_STAT, 0);
    $display("test status done");
    for (int k = 0; k < DSD_NUM_ERR; k++)
    begin
      err_event <= 6'(1 << k);
      @(posedge mclk);
      err_event <= '0;
      frames(8'h12 + 8'(k), 1);
      apb(0, DSD_OFS_DIAG_LO, 0);
      cmp_reg(r, {16'h0, 8'h12 + 8'(k), 8'h0a});
      cmp_reg({31'h0, irq}, 1);
      apb(0, DSD_OFS_IRQ_STAT, 0);
      cmp_reg(r, 3);
      apb(1, DSD_OFS_ERROR, 32'(1 << k));
      cmp_reg({31'h0, irq}, 0);
    end
    $display("test errors done");
    final_report;
  end
  // tests take under 1000 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    final_report;
  end
endmodule : tb_top
